// ==== hdl/cit_cfg.svh ====
// Offsets, field positions, reset values and counts of the interval timer
// Assumes inclusion by its bare name from the timer module
`ifndef CIT_CFG_SVH
`define CIT_CFG_SVH

// ****************************************************************
// Register offsets (byte addresses, one 32-bit word each)
// ****************************************************************
`define CIT_CTRL_ADDR    8'h00
`define CIT_CMD_ADDR     8'h04
`define CIT_STATUS_ADDR  8'h08
`define CIT_COUNT_ADDR   8'h0C
`define CIT_RESULT_ADDR  8'h10
`define CIT_FORMAT_ADDR  8'h14

// ****************************************************************
// Field positions
// ****************************************************************
`define CIT_MODE_LSB     0
`define CIT_INSEL_LSB    3
`define CIT_REAR_BIT     5
`define CIT_RATE_LSB     6
`define CIT_AVG_LSB      10
`define CIT_CLR_BIT      0

// ****************************************************************
// Reset values
// ****************************************************************
`define CIT_MODE_RST     3'h0
`define CIT_INSEL_RST    2'h0
`define CIT_REAR_RST     1'h0
`define CIT_RATE_RST     4'h0
`define CIT_AVG_RST      2'h0

// ****************************************************************
// Counts and limits
// ****************************************************************
`define CIT_TB_STAGES    8
`define CIT_RATE_MAX     4'h8
`define CIT_MULT_RATE_MAX 4'h2
`define CIT_DEAD_LAST    10'h3E7
`define CIT_BCD_FULL     32'h99999999

`endif

// ==== hdl/cit_pkg.sv ====
// Types of the crossing interval timer: modes, selections, states, result
// Assumes the constants of cit_cfg.svh for offsets and counts
package cit_pkg;

    typedef enum logic [2:0] {
        CIT_SINGLE_INT = 3'h0,
        CIT_SINGLE_EXT = 3'h1,
        CIT_MULT_INT   = 3'h2,
        CIT_MULT_EXT   = 3'h3,
        CIT_CONT_INT   = 3'h4,
        CIT_CONT_EXT   = 3'h5
    } cit_mode_t;

    typedef enum logic [1:0] {
        CIT_SEL_PRIMARY   = 2'h0,
        CIT_SEL_SECONDARY = 2'h1,
        CIT_SEL_SPLIT     = 2'h2
    } cit_insel_t;

    typedef enum logic [1:0] {
        CIT_S_IDLE = 2'b00,
        CIT_S_OPEN = 2'b01,
        CIT_S_HOLD = 2'b10,
        CIT_S_DEAD = 2'b11
    } cit_state_t;

    typedef enum logic [1:0] {
        CIT_UNIT_NONE = 2'h0,
        CIT_UNIT_US   = 2'h1,
        CIT_UNIT_MS   = 2'h2,
        CIT_UNIT_S    = 2'h3
    } cit_unit_t;

    typedef struct packed {
        logic [2:0] mode;
        logic [1:0] insel;
        logic       rear;
        logic [3:0] rate;
        logic [1:0] avg_exp;
    } cit_ctrl_t;

    typedef struct packed {
        logic [31:0] bcd;
        logic [2:0]  dp;
        cit_unit_t   unit;
        logic        ovf;
    } cit_result_t;

endpackage

// ==== hdl/cit_timer.sv ====
// Crossing interval timer: gated BCD counter between marker pulses
// Assumes pulse and count inputs synchronous to clock_i at 100 MHz
`timescale 1ns/1ps
`default_nettype none
`include "cit_cfg.svh"

module cit_timer (
    input  wire logic           clock_i,
    input  wire logic           reset_n_i,
    input  wire logic [7:0]     addr_i,
    input  wire logic [31:0]    wdata_i,
    input  wire logic           wr_i,
    input  wire logic           rd_i,
    output logic [31:0]         rdata_o,
    input  wire logic           primary_front_i,
    input  wire logic           primary_rear_i,
    input  wire logic           secondary_front_i,
    input  wire logic           secondary_rear_i,
    input  wire logic           ext_count_i,
    output cit_pkg::cit_result_t result_o,
    output logic                gate_o,
    output logic                reset_inhibit_o,
    output logic                end_of_count_o
);

    // ****************************************************************
    // BCD increment
    // ****************************************************************
    function automatic logic [32:0] cit_bcd_inc(input logic [31:0] v);
        logic [32:0] r;
        logic        c;
        r = 33'h0;
        c = 1'b1;
        for (int i = 0; i < 8; i++) begin
            if (c && (v[4*i +: 4] == 4'h9)) begin
                r[4*i +: 4] = 4'h0;
            end else begin
                r[4*i +: 4] = v[4*i +: 4] + {3'h0, c};
                c = 1'b0;
            end
        end
        r[32] = c;
        return r;
    endfunction

    cit_pkg::cit_ctrl_t  ctrl_reg;
    logic                clr_reg;
    cit_pkg::cit_state_t state_reg;
    cit_pkg::cit_state_t state_next;
    logic [31:0]         cnt_reg;
    logic                ovf_reg;
    logic [9:0]          intv_reg;
    logic [9:0]          dead_reg;
    logic [3:0]          div_reg [0:`CIT_TB_STAGES-1];
    logic [8:0]          tb;
    logic                prim_q;
    logic                sec_q;
    logic                ext_q;
    logic                mode_mult;
    logic                mode_cont;
    logic                mode_single;
    logic                ext_mode;
    logic                split;
    logic [3:0]          eff_rate;
    logic                prim;
    logic                sec;
    logic                prim_pulse;
    logic                sec_pulse;
    logic                chan_pulse;
    logic                start_ev;
    logic                stop_ev;
    logic                src_tick;
    logic                close;
    logic [9:0]          avg_n;
    logic [32:0]         inc;
    logic [2:0]          fmt_dp;
    cit_pkg::cit_unit_t  fmt_unit;

    // ****************************************************************
    // Register port
    // ****************************************************************
    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            ctrl_reg <= {`CIT_MODE_RST, `CIT_INSEL_RST, `CIT_REAR_RST, `CIT_RATE_RST, `CIT_AVG_RST};
        end else if (wr_i && (addr_i == `CIT_CTRL_ADDR)) begin
            ctrl_reg <= {wdata_i[`CIT_MODE_LSB +: 3], wdata_i[`CIT_INSEL_LSB +: 2],
                         wdata_i[`CIT_REAR_BIT], wdata_i[`CIT_RATE_LSB +: 4],
                         wdata_i[`CIT_AVG_LSB +: 2]};
        end
    end

    // Manual display reset command, one cycle
    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            clr_reg <= 1'b0;
        end else begin
            clr_reg <= wr_i && (addr_i == `CIT_CMD_ADDR) && wdata_i[`CIT_CLR_BIT];
        end
    end
    always_ff @(posedge clock_i) begin
        if (!reset_n_i || !rd_i) begin
            rdata_o <= 32'h0;
        end else begin
            unique case (addr_i)
                `CIT_CTRL_ADDR:   rdata_o <= {20'h0, ctrl_reg.avg_exp, ctrl_reg.rate,
                                              ctrl_reg.rear, ctrl_reg.insel, ctrl_reg.mode};
                `CIT_STATUS_ADDR: rdata_o <= {27'h0, ovf_reg, reset_inhibit_o, gate_o, state_reg};
                `CIT_COUNT_ADDR:  rdata_o <= cnt_reg;
                `CIT_RESULT_ADDR: rdata_o <= result_o.bcd;
                `CIT_FORMAT_ADDR: rdata_o <= {26'h0, result_o.ovf, result_o.unit, result_o.dp};
                default:          rdata_o <= 32'h0;
            endcase
        end
    end

    // ****************************************************************
    // Mode decode and source selection
    // ****************************************************************
    always_comb begin
        mode_mult   = (ctrl_reg.mode == cit_pkg::CIT_MULT_INT) ||
                      (ctrl_reg.mode == cit_pkg::CIT_MULT_EXT);
        mode_cont   = (ctrl_reg.mode == cit_pkg::CIT_CONT_INT) ||
                      (ctrl_reg.mode == cit_pkg::CIT_CONT_EXT);
        mode_single = !mode_mult && !mode_cont;
        ext_mode    = (ctrl_reg.mode == cit_pkg::CIT_SINGLE_EXT) ||
                      (ctrl_reg.mode == cit_pkg::CIT_MULT_EXT) ||
                      (ctrl_reg.mode == cit_pkg::CIT_CONT_EXT);
        split       = mode_single && (ctrl_reg.insel == cit_pkg::CIT_SEL_SPLIT);
        if (mode_mult) begin
            eff_rate = (ctrl_reg.rate > `CIT_MULT_RATE_MAX) ? `CIT_MULT_RATE_MAX
                                                           : ctrl_reg.rate;
        end else begin
            eff_rate = (ctrl_reg.rate > `CIT_RATE_MAX) ? `CIT_RATE_MAX : ctrl_reg.rate;
        end
        unique case (ctrl_reg.avg_exp)
            2'h0: avg_n = 10'h001;
            2'h1: avg_n = 10'h00A;
            2'h2: avg_n = 10'h064;
            2'h3: avg_n = 10'h3E8;
        endcase
    end

    always_comb begin
        prim       = ctrl_reg.rear ? primary_rear_i : primary_front_i;
        sec        = ctrl_reg.rear ? secondary_rear_i : secondary_front_i;
        prim_pulse = prim && !prim_q;
        sec_pulse  = sec && !sec_q;
        chan_pulse = (ctrl_reg.insel == cit_pkg::CIT_SEL_SECONDARY) ? sec_pulse : prim_pulse;
        start_ev   = split ? prim_pulse : chan_pulse;
        stop_ev    = split ? sec_pulse : chan_pulse;
    end

    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            prim_q <= 1'b0;
            sec_q  <= 1'b0;
            ext_q  <= 1'b0;
        end else begin
            prim_q <= prim;
            sec_q  <= sec;
            ext_q  <= ext_count_i;
        end
    end

    // ****************************************************************
    // Decade time base: tb[0] is the 100 MHz clock itself
    // ****************************************************************
    always_comb begin
        tb[0] = 1'b1;
        for (int i = 0; i < `CIT_TB_STAGES; i++) begin
            tb[i+1] = tb[i] && (div_reg[i] == 4'h9);
        end
    end
    always_ff @(posedge clock_i) begin
        for (int i = 0; i < `CIT_TB_STAGES; i++) begin
            if (!reset_n_i) begin
                div_reg[i] <= 4'h0;
            end else if (tb[i]) begin
                div_reg[i] <= (div_reg[i] == 4'h9) ? 4'h0 : div_reg[i] + 4'h1;
            end
        end
    end

    // External edges counted only in external modes
    assign src_tick = ext_mode ? (ext_count_i && !ext_q) : tb[eff_rate];

    // ****************************************************************
    // Gate control
    // ****************************************************************
    always_comb begin
        state_next = state_reg;
        close      = 1'b0;
        if (clr_reg) begin
            state_next = cit_pkg::CIT_S_IDLE;
        end else begin
            unique case (state_reg)
                cit_pkg::CIT_S_IDLE: begin
                    if (start_ev) begin
                        state_next = cit_pkg::CIT_S_OPEN;
                    end
                end
                cit_pkg::CIT_S_OPEN: begin
                    if (stop_ev && (!mode_mult || (intv_reg + 10'h1 >= avg_n))) begin
                        close      = 1'b1;
                        state_next = mode_cont ? cit_pkg::CIT_S_DEAD : cit_pkg::CIT_S_HOLD;
                    end
                end
                cit_pkg::CIT_S_HOLD: state_next = cit_pkg::CIT_S_HOLD;
                cit_pkg::CIT_S_DEAD: begin
                    if (src_tick && (dead_reg == `CIT_DEAD_LAST)) begin
                        state_next = cit_pkg::CIT_S_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            state_reg <= cit_pkg::CIT_S_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end
    // Completed intervals in average mode
    always_ff @(posedge clock_i) begin
        if (!reset_n_i || (state_reg != cit_pkg::CIT_S_OPEN)) begin
            intv_reg <= 10'h0;
        end else if (stop_ev && !close) begin
            intv_reg <= intv_reg + 10'h1;
        end
    end
    // Reset time between gates in continuous modes
    always_ff @(posedge clock_i) begin
        if (!reset_n_i || (state_reg != cit_pkg::CIT_S_DEAD)) begin
            dead_reg <= 10'h0;
        end else if (src_tick) begin
            dead_reg <= dead_reg + 10'h1;
        end
    end

    // ****************************************************************
    // BCD counter, fastest digit steps on each src_tick: time base tb[eff_rate] or external edge
    // ****************************************************************
    assign inc = cit_bcd_inc(cnt_reg);

    always_ff @(posedge clock_i) begin
        if (!reset_n_i || clr_reg) begin
            cnt_reg <= 32'h0;
            ovf_reg <= 1'b0;
        end else if ((state_reg == cit_pkg::CIT_S_IDLE) && start_ev) begin
            cnt_reg <= 32'h0;
            ovf_reg <= 1'b0;
        end else if (close && mode_cont) begin
            cnt_reg <= 32'h0;
            ovf_reg <= 1'b0;
        end else if ((state_reg == cit_pkg::CIT_S_OPEN) && src_tick && !ovf_reg) begin
            if (inc[32]) begin
                ovf_reg <= 1'b1;
            end else begin
                cnt_reg <= inc[31:0];
            end
        end
    end

    // ****************************************************************
    // Readout units and decimal point (digits right of the point)
    // ****************************************************************
    always_comb begin
        fmt_dp   = 3'h0;
        fmt_unit = cit_pkg::CIT_UNIT_NONE;
        if (!ext_mode && mode_mult) begin
            fmt_unit = cit_pkg::CIT_UNIT_US;
            fmt_dp   = 3'(4'h2 - eff_rate) + {1'b0, ctrl_reg.avg_exp};
        end else if (!ext_mode) begin
            if (eff_rate < 4'h3) begin
                fmt_unit = cit_pkg::CIT_UNIT_US;
                fmt_dp   = 3'(4'h2 - eff_rate);
            end else if (eff_rate < 4'h6) begin
                fmt_unit = cit_pkg::CIT_UNIT_MS;
                fmt_dp   = 3'(4'h5 - eff_rate);
            end else begin
                fmt_unit = cit_pkg::CIT_UNIT_S;
                fmt_dp   = 3'(4'h8 - eff_rate);
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (!reset_n_i || clr_reg) begin
            result_o <= '0;
        end else if (close) begin
            result_o.bcd  <= cnt_reg;
            result_o.dp   <= fmt_dp;
            result_o.unit <= fmt_unit;
            result_o.ovf  <= ovf_reg;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            gate_o          <= 1'b0;
            reset_inhibit_o <= 1'b0;
            end_of_count_o  <= 1'b0;
        end else begin
            gate_o          <= state_next == cit_pkg::CIT_S_OPEN;
            reset_inhibit_o <= (state_next == cit_pkg::CIT_S_OPEN) ||
                               (state_next == cit_pkg::CIT_S_DEAD);
            end_of_count_o  <= close;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);

    a_split_opens: assert property (
        (split && state_reg == cit_pkg::CIT_S_IDLE && prim_pulse && !clr_reg)
        |=> gate_o ##0 (state_reg == cit_pkg::CIT_S_OPEN))
        else $error("split start did not open gate");
    a_split_closes: assert property (
        (split && state_reg == cit_pkg::CIT_S_OPEN && sec_pulse && !clr_reg)
        |=> !gate_o && end_of_count_o)
        else $error("split stop did not close gate");
    a_common_closes: assert property (
        (!split && !mode_mult && state_reg == cit_pkg::CIT_S_OPEN && chan_pulse && !clr_reg)
        |=> state_reg != cit_pkg::CIT_S_OPEN)
        else $error("common channel pulse did not close gate");
    a_mult_rates: assert property (
        mode_mult |-> eff_rate <= 4'h2)
        else $error("average mode rate out of range");
    a_ext_source: assert property (
        (ext_mode && state_reg == cit_pkg::CIT_S_OPEN && !(ext_count_i && !ext_q) && !clr_reg
         && !(close && mode_cont))
        |=> $stable(cnt_reg))
        else $error("count moved without an external edge");
    a_cont_reset: assert property (
        (mode_cont && close && !clr_reg)
        |=> (cnt_reg == 32'h0) && (state_reg == cit_pkg::CIT_S_DEAD) && reset_inhibit_o)
        else $error("continuous stop did not reset count");
    a_hold_persists: assert property (
        (state_reg == cit_pkg::CIT_S_HOLD && !clr_reg)
        |=> (state_reg == cit_pkg::CIT_S_HOLD) && $stable(result_o))
        else $error("held result changed without reset");
    a_dead_length: assert property (
        (state_reg == cit_pkg::CIT_S_DEAD && state_next == cit_pkg::CIT_S_IDLE && !clr_reg)
        |-> $past(dead_reg) >= 10'h3E6)
        else $error("dead time shorter than 1000 counts");
    a_ext_no_unit: assert property (
        (close && ext_mode && !clr_reg) |=> result_o.unit == cit_pkg::CIT_UNIT_NONE)
        else $error("external result carries a unit");
    a_avg_units: assert property (
        (close && mode_mult && !ext_mode && !clr_reg) |=> result_o.unit == cit_pkg::CIT_UNIT_US)
        else $error("average result not in microseconds");
    a_overflow_flag: assert property (
        (state_reg == cit_pkg::CIT_S_OPEN && src_tick && cnt_reg == `CIT_BCD_FULL
         && !ovf_reg && !clr_reg && !close)
        |=> ovf_reg && (cnt_reg == `CIT_BCD_FULL))
        else $error("overflow wrapped the count");
    a_split_single: assert property (
        !mode_single |-> !split)
        else $error("split selection outside single modes");

    c_single_done: cover property (mode_single && close);
    c_cont_rearm: cover property (state_reg == cit_pkg::CIT_S_DEAD ##1
                                  state_reg == cit_pkg::CIT_S_IDLE);
    c_mult_done: cover property (mode_mult && close && avg_n == 10'h00A);
    c_overflow: cover property ($rose(ovf_reg));

endmodule
`default_nettype wire

// ==== bench/cit_pulser.sv ====
// Marker pulse source standing in for the crossing analyzer
// Assumes one strobe per line from the bench, on the 100 MHz clock
`timescale 1ns/1ps
`default_nettype none

module cit_pulser #(
    parameter int WIDTH = 10
) (
    input  wire logic       clock_i,
    input  wire logic [3:0] fire_i,
    output logic      [3:0] line_o
);
    int cnt [4] = '{0, 0, 0, 0};

    // Each strobe gives one rectangular pulse of WIDTH cycles, idle low between
    always @(posedge clock_i) begin
        for (int i = 0; i < 4; i++) begin
            if (fire_i[i]) begin
                cnt[i] <= WIDTH;
            end else if (cnt[i] > 0) begin
                cnt[i] <= cnt[i] - 1;
            end
        end
    end

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            line_o[i] = (cnt[i] != 0);
        end
    end
endmodule
`default_nettype wire

// ==== bench/tb.sv ====
// Testbench of the crossing interval timer: table of measurements, then hand cases
// Assumes cit_timer, cit_pulser and the constants of cit_cfg.svh
`timescale 1ns/1ps
`default_nettype none
`include "cit_cfg.svh"

module tb;
    typedef struct {
        int mode; int insel; int rear; int rate; int avg;
        int a; int b; int n; int gap; int cnt; int dp; int unit;
    } cit_row_t;

    // Lines: 0 primary front, 1 primary rear, 2 secondary front, 3 secondary rear
    cit_row_t rows [8] = '{
        '{0, 0, 0, 0, 0, 0, 0, 1, 50, 49, 2, 1},
        '{0, 1, 0, 1, 0, 2, 2, 1, 200, 20, 1, 1},
        '{0, 2, 0, 3, 0, 0, 2, 1, 3000, 3, 2, 2},
        '{0, 0, 1, 2, 0, 1, 1, 1, 300, 3, 0, 1},
        '{1, 2, 0, 0, 0, 0, 2, 1, 400, 100, 0, 0},
        '{2, 0, 0, 7, 1, 0, 0, 10, 100, 10, 1, 1},
        '{5, 0, 0, 0, 0, 0, 0, 1, 200, 50, 0, 0},
        '{3, 1, 0, 0, 0, 2, 2, 1, 200, 50, 0, 0}
    };

    logic                 clock_i   = 1'b0;
    logic                 reset_n_i = 1'b0;
    logic [7:0]           addr      = 8'h00;
    logic [31:0]          wdata     = 32'h00000000;
    logic                 wr        = 1'b0;
    logic                 rd        = 1'b0;
    logic [3:0]           fire      = 4'h0;
    logic [1:0]           ext_div   = 2'h0;
    logic [3:0]           line;
    logic [31:0]          rdata;
    logic [31:0]          d;
    logic [31:0]          save;
    cit_pkg::cit_result_t result;
    logic                 gate;
    logic                 inhibit;
    logic                 eoc;
    int                   cyc       = 0;
    int                   t0;
    int                   n_fail    = 0;
    int                   n_checks  = 0;

    always #5 clock_i = ~clock_i;
    always @(posedge clock_i) ext_div <= ext_div + 2'h1;
    always @(posedge clock_i) cyc <= cyc + 1;

    cit_timer i_dut (
        .clock_i(clock_i), .reset_n_i(reset_n_i), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .primary_front_i(line[0]),
        .primary_rear_i(line[1]), .secondary_front_i(line[2]), .secondary_rear_i(line[3]),
        .ext_count_i(ext_div[1]), .result_o(result), .gate_o(gate),
        .reset_inhibit_o(inhibit), .end_of_count_o(eoc)
    );
    cit_pulser i_pulser (.clock_i(clock_i), .fire_i(fire), .line_o(line));

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic end_of_test();
        $display("checks=%0d failures=%0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // BCD count compared with one count of slack either way
    task automatic near(input logic [31:0] bcd, input int exp);
        int v;
        v = 0;
        for (int i = 7; i >= 0; i--) v = v * 10 + int'(bcd[i*4 +: 4]);
        n_checks++;
        if ((^bcd === 1'bx) || v + 1 < exp || v > exp + 1) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, bcd, exp);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
        @(posedge clock_i);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clock_i);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
        @(posedge clock_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock_i);
        rd <= 1'b0;
        #1 v = rdata;
    endtask

    task automatic pulse(input int idx);
        @(posedge clock_i);
        fire[idx] <= 1'b1;
        @(posedge clock_i);
        fire[idx] <= 1'b0;
    endtask

    task automatic wait_eoc();
        int k;
        for (k = 0; k < 200; k++) begin
            @(posedge clock_i);
            #1;
            if (eoc === 1'b1) break;
        end
        if (k == 200) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
            end_of_test();
        end
    endtask

    // ****************************************************************
    // Sequence
    // ****************************************************************
    initial begin
        repeat (16) @(posedge clock_i);
        reset_n_i <= 1'b1;
        @(posedge clock_i);
        #1;
        chk(result.bcd, 32'h0);
        chk(32'({gate, inhibit, eoc}), 32'h0);
        rd_reg(`CIT_CTRL_ADDR, d);
        chk(d, 32'h0);
        rd_reg(8'h1C, d);
        chk(d, 32'h0);
        foreach (rows[i]) begin
            wr_reg(`CIT_CMD_ADDR, 32'h1);
            save = {20'h0, 2'(rows[i].avg), 4'(rows[i].rate),
                    1'(rows[i].rear), 2'(rows[i].insel), 3'(rows[i].mode)};
            wr_reg(`CIT_CTRL_ADDR, save);
            rd_reg(`CIT_CTRL_ADDR, d);
            chk(d, save);
            pulse(rows[i].a);
            repeat (rows[i].n) begin
                repeat (rows[i].gap - 2) @(posedge clock_i);
                pulse(rows[i].b);
            end
            wait_eoc();
            near(result.bcd, rows[i].cnt);
            rd_reg(`CIT_FORMAT_ADDR, d);
            chk(d, 32'(rows[i].dp + rows[i].unit * 8));
        end
        // Held result ignores later pulses until a manual clear
        save = result.bcd;
        pulse(2);
        repeat (30) @(posedge clock_i);
        #1;
        chk(result.bcd, save);
        chk(32'(gate), 32'h0);
        wr_reg(`CIT_CMD_ADDR, 32'h1);
        repeat (2) @(posedge clock_i);
        #1;
        chk(result.bcd, 32'h0);
        // Continuous: dead time, then the next interval replaces the result
        wr_reg(`CIT_CTRL_ADDR, 32'h4);
        pulse(0);
        repeat (48) @(posedge clock_i);
        pulse(0);
        wait_eoc();
        t0 = cyc;
        near(result.bcd, 49);
        rd_reg(`CIT_STATUS_ADDR, d);
        chk(d, 32'h0000000B);
        pulse(0);
        repeat (20) @(posedge clock_i);
        #1;
        chk(32'(gate), 32'h0);
        while (inhibit === 1'b1 && cyc - t0 < 1100) begin
            @(posedge clock_i);
            #1;
        end
        chk(32'(cyc - t0 >= 995 && cyc - t0 <= 1005), 32'h1);
        pulse(0);
        repeat (5) @(posedge clock_i);
        #1;
        chk(32'({gate, inhibit}), 32'h3);
        repeat (73) @(posedge clock_i);
        pulse(0);
        wait_eoc();
        near(result.bcd, 79);
        // Mid-run reset during the dead time clears every output
        reset_n_i <= 1'b0;
        repeat (2) @(posedge clock_i);
        #1;
        chk(32'({gate, inhibit, eoc}), 32'h0);
        chk(result.bcd, 32'h0);
        reset_n_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        end_of_test();
    end
endmodule
`default_nettype wire
